/* core/config_status_indicator.sv */
/*
  Configuration status lamps of the board configuration controller.
  Assumes the flash loader reports scan result, transfer activity and
  outcome as synchronous levels and one-cycle pulses on clk_i.
*/
`timescale 1ns/1ps
`default_nettype none

module config_status_indicator
#(
  parameter int unsigned BLINK_HALF = cfg_lamp_pkg::BLINK_HALF_CYC,
  parameter logic [3:0] LAMP_POL = cfg_lamp_pkg::LAMP_POL_RST
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Flash scan result
  input wire logic scan_done_i,
  input wire logic user_valid_i,
  input wire logic factory_valid_i,
  // Transfer progress
  input wire logic xfer_busy_i,
  input wire logic xfer_done_i,
  input wire logic xfer_fail_i,
  // JTAG download and pin state of the loaded design
  input wire logic jtag_load_i,
  input wire logic pins_tristate_i,
  // Lamps
  output logic user_image_lamp_o,
  output logic factory_image_lamp_o,
  output logic loading_activity_lamp_o,
  output logic load_error_lamp_o
);

  import cfg_lamp_pkg::*;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // ---------------------------------------------------------------
  // Load sequence
  // ---------------------------------------------------------------
  lamp_state_t state_q;
  lamp_state_t state_d;

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_IDLE: begin
        if (scan_done_i) begin
          if (user_valid_i) begin
            state_d = ST_LOAD_USER;
          end else if (factory_valid_i) begin
            state_d = ST_LOAD_FACTORY;
          end else begin
            state_d = ST_FAILED;
          end
        end
      end
      ST_LOAD_USER: begin
        if (xfer_done_i) begin
          state_d = ST_DONE_USER;
        end else if (xfer_fail_i) begin
          state_d = factory_valid_i ? ST_LOAD_FACTORY : ST_FAILED;
        end
      end
      ST_LOAD_FACTORY: begin
        if (xfer_done_i) begin
          state_d = ST_DONE_FACTORY;
        end else if (xfer_fail_i) begin
          state_d = ST_FAILED;
        end
      end
      ST_DONE_USER, ST_DONE_FACTORY, ST_FAILED, ST_JTAG: begin
        if (jtag_load_i) begin
          state_d = ST_JTAG;
        end
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // ---------------------------------------------------------------
  // Blink divider
  // ---------------------------------------------------------------
  logic [BLINK_CNT_W-1:0] blink_cnt_q;
  logic [BLINK_CNT_W-1:0] blink_cnt_d;
  logic blink_q;
  logic blink_d;
  logic blink_tick;
  logic loading;

  assign loading = (state_q == ST_LOAD_USER || state_q == ST_LOAD_FACTORY)
                   && xfer_busy_i;
  assign blink_tick = (blink_cnt_q == BLINK_CNT_W'(BLINK_HALF - 1));

  always_comb begin
    blink_cnt_d = blink_cnt_q;
    blink_d = blink_q;
    if (!loading) begin
      blink_cnt_d = '0;
      blink_d = 1'b1;
    end else if (blink_tick) begin
      blink_cnt_d = '0;
      blink_d = ~blink_q;
    end else begin
      blink_cnt_d = blink_cnt_q + BLINK_CNT_W'(1);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      blink_cnt_q <= '0;
      blink_q <= 1'b1;
    end else begin
      blink_cnt_q <= blink_cnt_d;
      blink_q <= blink_d;
    end
  end

  // ---------------------------------------------------------------
  // Lamp drive
  // ---------------------------------------------------------------
  logic [LAMP_N-1:0] lit_d;
  logic [LAMP_N-1:0] lamp_q;
  logic [LAMP_N-1:0] lit_now;

  assign lit_now = ~(lamp_q ^ LAMP_POL);

  always_comb begin
    lit_d = '0;
    lit_d[LAMP_LOADING] = loading && blink_q;
    unique case (state_q)
      ST_IDLE: begin
        lit_d = '0;
      end
      ST_LOAD_USER, ST_DONE_USER: begin
        lit_d[LAMP_USER] = 1'b1;
      end
      ST_LOAD_FACTORY, ST_DONE_FACTORY: begin
        lit_d[LAMP_FACTORY] = 1'b1;
      end
      ST_FAILED: begin
        lit_d[LAMP_ERROR] = 1'b1;
      end
      ST_JTAG: begin
        lit_d = pins_tristate_i ? '0 : lit_now;
        lit_d[LAMP_USER] = 1'b1;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lamp_q <= ~LAMP_POL;
    end else begin
      lamp_q <= ~(lit_d ^ LAMP_POL);
    end
  end

  assign user_image_lamp_o = lamp_q[LAMP_USER];
  assign factory_image_lamp_o = lamp_q[LAMP_FACTORY];
  assign loading_activity_lamp_o = lamp_q[LAMP_LOADING];
  assign load_error_lamp_o = lamp_q[LAMP_ERROR];

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  sequence s_no_image;
    state_q == ST_IDLE && scan_done_i && !user_valid_i && !factory_valid_i;
  endsequence

  sequence s_user_start;
    state_q == ST_IDLE && scan_done_i && user_valid_i;
  endsequence

  property p_reset_dark;
    @(posedge clk_i) disable iff (1'b0)
      rst_i |=> lit_now == '0;
  endproperty
  a_reset_dark: assert property (p_reset_dark)
    else $error("lamps not dark after reset");

  property p_no_image_error;
    s_no_image |=> ##1 lit_now[LAMP_ERROR] && !lit_now[LAMP_USER];
  endproperty
  a_no_image_error: assert property (p_no_image_error)
    else $error("empty flash did not raise error lamp");

  property p_failed_error;
    state_q == ST_FAILED |=> lit_now[LAMP_ERROR];
  endproperty
  a_failed_error: assert property (p_failed_error)
    else $error("error lamp dark after failed load");

  property p_user_load;
    s_user_start |=> ##1 lit_now[LAMP_USER] && !lit_now[LAMP_ERROR];
  endproperty
  a_user_load: assert property (p_user_load)
    else $error("user lamp dark during user transfer");

  property p_user_stays;
    state_q == ST_DONE_USER |=> lit_now[LAMP_USER];
  endproperty
  a_user_stays: assert property (p_user_stays)
    else $error("user lamp dark after user load");

  property p_factory_lamp;
    (state_q == ST_LOAD_FACTORY || state_q == ST_DONE_FACTORY)
      |=> lit_now[LAMP_FACTORY] && !lit_now[LAMP_USER];
  endproperty
  a_factory_lamp: assert property (p_factory_lamp)
    else $error("factory lamp wrong during factory load");

  property p_jtag_user;
    jtag_load_i && (state_q == ST_DONE_USER || state_q == ST_DONE_FACTORY ||
      state_q == ST_FAILED || state_q == ST_JTAG) |=> ##1 lit_now[LAMP_USER];
  endproperty
  a_jtag_user: assert property (p_jtag_user)
    else $error("user lamp dark after jtag download");

  property p_tristate_dark;
    state_q == ST_JTAG && pins_tristate_i
      |=> lit_now == 4'h1;
  endproperty
  a_tristate_dark: assert property (p_tristate_dark)
    else $error("other lamps lit with tri-stated pins");

  property p_blink_idle;
    !loading |=> !lit_now[LAMP_LOADING];
  endproperty
  a_blink_idle: assert property (p_blink_idle)
    else $error("loading lamp lit while not transferring");

  property p_blink_rate;
    loading && $past(loading) && $changed(blink_q) |-> $past(blink_tick);
  endproperty
  a_blink_rate: assert property (p_blink_rate)
    else $error("blink toggled off the divider tick");

  property p_one_outcome;
    state_q != ST_JTAG |=>
      !(lit_now[LAMP_ERROR] && (lit_now[LAMP_USER] || lit_now[LAMP_FACTORY]));
  endproperty
  a_one_outcome: assert property (p_one_outcome)
    else $error("error lamp lit together with image lamp");

endmodule

`default_nettype wire

/* common/cfg_lamp_pkg.sv */
/*
  Constants for the configuration status lamp block: lamp positions,
  lamp polarity default and blink timing.
  Assumes a single 40 MHz system clock.
*/
package cfg_lamp_pkg;

  // ---------------------------------------------------------------
  // Clock
  // ---------------------------------------------------------------
  localparam int unsigned CLK_HZ = 40_000_000;

  // ---------------------------------------------------------------
  // Lamp positions in the lamp vector
  // ---------------------------------------------------------------
  localparam int unsigned LAMP_N = 4;
  localparam int unsigned LAMP_USER = 0;
  localparam int unsigned LAMP_FACTORY = 1;
  localparam int unsigned LAMP_LOADING = 2;
  localparam int unsigned LAMP_ERROR = 3;

  // ---------------------------------------------------------------
  // Polarity: bit set means the lamp is lit by a high output
  // ---------------------------------------------------------------
  localparam logic [LAMP_N-1:0] LAMP_POL_RST = 4'hF;

  // ---------------------------------------------------------------
  // Blink timing: half period in milliseconds, then in cycles
  // ---------------------------------------------------------------
  localparam int unsigned BLINK_HALF_MS = 125;
  localparam int unsigned BLINK_HALF_CYC =
    (CLK_HZ / 1000) * BLINK_HALF_MS;
  localparam int unsigned BLINK_CNT_W = 24;

  // ---------------------------------------------------------------
  // Controller states
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_LOAD_USER,
    ST_LOAD_FACTORY,
    ST_DONE_USER,
    ST_DONE_FACTORY,
    ST_FAILED,
    ST_JTAG
  } lamp_state_t;

endpackage

/* test/flash_source_model.sv */
/*
  Flash image source: scan result, image moves, done or fail pulses.
  Assumes bench commands change at the falling edge of clk_i.
*/
`timescale 1ns/1ps
`default_nettype none
module flash_source_model (
  // Clock and command
  input wire logic clk_i,
  input wire logic go_i,
  input wire logic uv_i,
  input wire logic fv_i,
  input wire logic uok_i,
  input wire logic fok_i,
  input wire logic [3:0] len_i,
  // Toward the block, and fin_o toward the bench
  output logic scan_done_o,
  output logic user_valid_o,
  output logic factory_valid_o,
  output logic busy_o,
  output logic done_o,
  output logic fail_o,
  output logic fin_o
);
  initial begin
    {scan_done_o, user_valid_o, factory_valid_o} = 3'h0;
    {busy_o, done_o, fail_o, fin_o} = 4'h0;
  end
  // One image move, then its outcome pulse
  task automatic move(input logic ok, input logic last);
    busy_o <= 1'b1;
    repeat (len_i) @(negedge clk_i);
    busy_o <= 1'b0;
    done_o <= ok;
    fail_o <= !ok;
    fin_o <= last;
    @(negedge clk_i);
    {done_o, fail_o, fin_o} <= 3'h0;
  endtask
  always begin
    @(negedge clk_i);
    if (go_i) begin
      scan_done_o <= 1'b1;
      user_valid_o <= uv_i;
      factory_valid_o <= fv_i;
      fin_o <= !(uv_i || fv_i);
      @(negedge clk_i);
      {scan_done_o, fin_o} <= 2'h0;
      if (user_valid_o) begin
        move(uok_i, uok_i || !factory_valid_o);
        if (!uok_i && factory_valid_o) move(fok_i, 1'b1);
      end else if (factory_valid_o) move(fok_i, 1'b1);
    end
  end
endmodule
`default_nettype wire

/* test/config_status_indicator_tb_top.sv */
/*
  Self-checking bench for the configuration status lamps.
  Assumes the flash source model; checks active high lamps and mixed polarity POL_MIX lamps.
*/
`timescale 1ns/1ps
`default_nettype none
module config_status_indicator_tb_top;
  import cfg_lamp_pkg::*;
  // ---------------------------------------------------------------
  // Signals
  // ---------------------------------------------------------------
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic go, uv, fv, uok, fok, jtag, tri_s;
  logic [3:0] len;
  logic sd, uvl, fvl, busy, done, fail, fin;
  logic [3:0] lamps;
  logic [3:0] lamps_mix;
  logic [3:0] exp_now;
  localparam logic [3:0] POL_MIX = 4'h5;
  logic [3:0] exp_q[$];
  logic [31:0] lfsr = 32'h0000BBD1;
  int n_errors = 0;
  int total_checks = 0;
  int cyc = 0;
  event chk_ev;
  always #12.5 clk_i = ~clk_i;
  config_status_indicator #(.BLINK_HALF(4)) u_dut (
    .clk_i(clk_i), .rst_i(rst_i), .scan_done_i(sd),
    .user_valid_i(uvl), .factory_valid_i(fvl), .xfer_busy_i(busy),
    .xfer_done_i(done), .xfer_fail_i(fail), .jtag_load_i(jtag),
    .pins_tristate_i(tri_s), .user_image_lamp_o(lamps[0]),
    .factory_image_lamp_o(lamps[1]), .loading_activity_lamp_o(lamps[2]),
    .load_error_lamp_o(lamps[3]));
  config_status_indicator #(.BLINK_HALF(4), .LAMP_POL(POL_MIX)) u_dut_mix (
    .clk_i(clk_i), .rst_i(rst_i), .scan_done_i(sd),
    .user_valid_i(uvl), .factory_valid_i(fvl), .xfer_busy_i(busy),
    .xfer_done_i(done), .xfer_fail_i(fail), .jtag_load_i(jtag),
    .pins_tristate_i(tri_s), .user_image_lamp_o(lamps_mix[0]),
    .factory_image_lamp_o(lamps_mix[1]),
    .loading_activity_lamp_o(lamps_mix[2]),
    .load_error_lamp_o(lamps_mix[3]));
  flash_source_model u_src (
    .clk_i(clk_i), .go_i(go), .uv_i(uv), .fv_i(fv), .uok_i(uok),
    .fok_i(fok), .len_i(len), .scan_done_o(sd), .user_valid_o(uvl),
    .factory_valid_o(fvl), .busy_o(busy), .done_o(done),
    .fail_o(fail), .fin_o(fin));
  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  function automatic logic [31:0] lfsr_next(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  task automatic check(input string what, input logic [3:0] seen,
                       input logic [3:0] want);
    total_checks++;
    if (seen !== want) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", what, want, seen);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic edges(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  task automatic expect_lamps(input logic [3:0] e);
    @(negedge clk_i);
    exp_q.push_back(e);
    -> chk_ev;
  endtask
  task automatic do_reset();
    @(negedge clk_i);
    rst_i <= 1'b1;
    tri_s <= 1'b0;
    edges(6);
    expect_lamps(4'h0);
    rst_i <= 1'b0;
    expect_lamps(4'h0);
  endtask
  task automatic run(input logic u, f, uo, fo, input logic [3:0] fe);
    lfsr = lfsr_next(lfsr);
    @(negedge clk_i);
    {uv, fv, uok, fok} <= {u, f, uo, fo};
    len <= 4'h6 + {1'b0, lfsr[2:0]};
    go <= 1'b1;
    @(negedge clk_i);
    go <= 1'b0;
    while (!sd) @(negedge clk_i);
    if (u || f) begin
      edges(2);
      expect_lamps({2'b01, f && !u, u});
      edges(4);
      expect_lamps({2'b00, f && !u, u});
    end
    while (!fin) @(negedge clk_i);
    edges(2);
    expect_lamps(fe);
  endtask
  task automatic jtag_pulse(input logic t, input logic [3:0] e);
    @(negedge clk_i);
    jtag <= 1'b1;
    tri_s <= t;
    @(negedge clk_i);
    jtag <= 1'b0;
    edges(2);
    expect_lamps(e);
  endtask
  // ---------------------------------------------------------------
  // Checker, timeout and sequence
  // ---------------------------------------------------------------
  always begin
    @(chk_ev);
    exp_now = exp_q.pop_front();
    check("lamps", lamps, exp_now);
    check("lamps_mix", lamps_mix, exp_now ^ ~POL_MIX);
  end
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_errors++;
      stop_test();
    end
  end
  initial begin
    {go, uv, fv, uok, fok, jtag, tri_s} = 7'h0;
    len = 4'h6;
    do_reset();
    run(1, 0, 1, 0, 4'h1);
    jtag_pulse(0, 4'h1);
    do_reset();
    run(0, 0, 0, 0, 4'h8);
    do_reset();
    run(1, 1, 0, 1, 4'h2);
    jtag_pulse(0, 4'h3);
    do_reset();
    run(1, 0, 0, 0, 4'h8);
    jtag_pulse(0, 4'h9);
    jtag_pulse(1, 4'h1);
    do_reset();
    run(0, 1, 0, 0, 4'h8);
    edges(4);
    stop_test();
  end
endmodule
`default_nettype wire
